// >>> rtl/chgp_regs.vh
// Offsets, field positions, reset values and timing of the charger host port.
`ifndef CHGP_REGS_VH
`define CHGP_REGS_VH
// Serial port address and register offsets.
`define CHGP_SLAVE_ADDR 7'h6b
`define CHGP_ADDR_INPUT_SRC 8'h00
`define CHGP_ADDR_POWER_ON 8'h01
`define CHGP_ADDR_TERM_TIMER 8'h05
`define CHGP_ADDR_LAST_RW 8'h07
`define CHGP_ADDR_STATUS 8'h08
`define CHGP_ADDR_FAULT 8'h09
`define CHGP_ADDR_IDENT 8'h0a
// Reset values; the identity value is arbitrary.
`define CHGP_RST_INPUT_SRC 8'h58
`define CHGP_RST_POWER_ON 8'h1b
`define CHGP_RST_TERM_TIMER 8'h9c
`define CHGP_RST_OTHER 8'h00
`define CHGP_IDENT_VALUE 8'h25
// Field positions.
`define CHGP_PWR_REG_RESET 7
`define CHGP_PWR_WDT_KICK 6
`define CHGP_PWR_CHG_EN 4
`define CHGP_TT_TERM_EN 7
`define CHGP_TT_WDT_HI 5
`define CHGP_TT_WDT_LO 4
`define CHGP_TT_SAFE_EN 3
`define CHGP_FLT_DEFAULT 7
`define CHGP_FLT_BAT 3
`define CHGP_STS_THERM_REG 1
// Charge fault field codes.
`define CHGP_CF_NONE 2'h0
`define CHGP_CF_INPUT_OV 2'h1
`define CHGP_CF_THERM_SD 2'h2
`define CHGP_CF_TIMER 2'h3
// Timing figures in their own units.
`define CHGP_CLK_MHZ 200
`define CHGP_US_PER_SEC 1000000
`define CHGP_INT_PULSE_US 256
`define CHGP_SHORT_DELAY_US 1000
`define CHGP_SAFETY_HOURS 12
`define CHGP_SEC_PER_HOUR 3600
`define CHGP_WDT_BASE_SEC 40
`endif

// >>> rtl/chgp_sync.v
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/10ps
module chgp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire [W-1:0] asyncIn, // Inputs from outside the clock domain.
  output reg [W-1:0] syncOut // Filtered synchronous copy.
);
  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;
  reg [W-1:0] stage3_q;
  wire [W-1:0] agree;

  // A bit is accepted only where the second and third stages agree.
  assign agree = ~(stage2_q ^ stage3_q);

  // Shift the stages and update the output per agreeing bit.
  always @(posedge clk_sys) begin
    if (rst) begin
      stage1_q <= INIT;
      stage2_q <= INIT;
      stage3_q <= INIT;
      syncOut <= INIT;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      syncOut <= (stage3_q & agree) | (syncOut & ~agree);
    end
  end
endmodule // chgp_sync

// >>> rtl/chgp_oneshot.v
// Retriggerable one-shot that holds busy for a fixed number of cycles.
`timescale 1ns/10ps
module chgp_oneshot #(
  parameter [31:0] CYCLES = 32'h0000_0010
) (
  input wire clk_sys, // System clock.
  input wire rst, // Synchronous reset, active high.
  input wire trigger, // Start or restart the interval.
  output reg busy // High for CYCLES cycles after a trigger.
);
  reg [31:0] count_q;

  // Load on trigger, then count down to zero and drop busy.
  always @(posedge clk_sys) begin
    if (rst) begin
      count_q <= 32'h0000_0000;
      busy <= 1'b0;
    end else if (trigger) begin
      count_q <= CYCLES - 32'h0000_0001;
      busy <= 1'b1;
    end else if (busy) begin
      if (count_q == 32'h0000_0000) begin
        busy <= 1'b0;
      end else begin
        count_q <= count_q - 32'h0000_0001;
      end
    end
  end
endmodule // chgp_oneshot

// >>> rtl/chgp_top.v
// Charger host port: serial slave, fault latch, interrupt and supervision.
//
// Contract
// - Events give one 256 us interrupt pulse.
// - Source, input, removal, done events never masked.
// - Fault pulses interrupt, latched until fault read.
// - Latched fault suppresses new interrupts except thermistor; input overvoltage still interrupts.
// - Thermistor field is live, never latched.
// - First read latched faults, second read present.
// - Thermal regulation: no termination, half timer, status.
// - Thermal shutdown stops converter, code 10, interrupt.
// - Input overvoltage stops switching, code 01, interrupt.
// - Battery overvoltage stops charge, bit 3, interrupt.
// - Battery short: switch off, 1 ms, 100 mA.
// - Fault bit 7 high default, low host.
// - Reset starts default mode, 12-hour timer.
// - Any write moves device into host mode.
// - Slave answers at seven-bit address 6BH.
// - Port works at 100 and 400 kbit/s.
// - Data changes only while clock is low.
// - Master makes start and stop; busy between.
// - Eight bits, MSB first, then acknowledge.
// - Slave may stretch clock between bytes; this slave never does, sclOe stays low.
// - Undefined register gets not-acknowledge, port idles.
// - Fault register only single-byte reads.
`timescale 1ns/10ps
`include "chgp_regs.vh"
module chgp_top #(
  parameter [31:0] INT_CYCLES = `CHGP_INT_PULSE_US * `CHGP_CLK_MHZ,
  parameter [31:0] SHORT_CYCLES = `CHGP_SHORT_DELAY_US * `CHGP_CLK_MHZ,
  parameter [31:0] SEC_CYCLES = `CHGP_US_PER_SEC * `CHGP_CLK_MHZ,
  parameter [31:0] SAFETY_SEC = `CHGP_SAFETY_HOURS * `CHGP_SEC_PER_HOUR,
  parameter [31:0] WDT_BASE_SEC = `CHGP_WDT_BASE_SEC
) (
  input wire clk_sys, // System clock, 200 MHz.
  input wire rst, // Synchronous reset, active high.
  input wire sclIn, // Serial clock pin level.
  output wire sclOut, // Serial clock drive value.
  output wire sclOe, // Serial clock pulled low when high.
  input wire sdaIn, // Serial data pin level.
  output wire sdaOut, // Serial data drive value.
  output wire sdaOe, // Serial data pulled low when high.
  input wire srcIdentIn, // Source type detection finished.
  input wire goodInputIn, // Good input source present.
  input wire inputRemovedIn, // Input supply rail removed.
  input wire inputOvIn, // Input overvoltage comparator.
  input wire chargeDoneIn, // Charge cycle complete.
  input wire thermalRegIn, // Junction in thermal regulation.
  input wire thermalSdIn, // Junction thermal shutdown.
  input wire batteryOvIn, // Battery overvoltage comparator.
  input wire batteryShortIn, // Battery below short threshold.
  input wire [2:0] thermistorFaultIn, // Battery thermistor condition.
  input wire [1:0] chargePhaseIn, // Charge phase code.
  input wire [1:0] srcTypeIn, // Detected source type code.
  output wire hostIntN, // Host interrupt, low during pulse.
  output wire defaultMode, // High in default mode.
  output wire converterOn, // Converter may switch.
  output wire chargeEnable, // Charging allowed.
  output wire terminationEnable, // Charge termination allowed.
  output wire timerHalfRate, // Safety timer at half rate.
  output wire safetyExpired, // Safety timer has expired.
  output wire batterySwitchOn, // Battery switch closed.
  output wire chargeLow100mA, // Charge at the 100 mA level.
  output wire [7:0] inputSourceCfg, // Input source control value.
  output wire [7:0] powerOnCfg, // Power-on configuration value.
  output wire [7:0] termTimerCfg // Termination and timer control value.
);
  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_PACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [17:0] SYNC_INIT = 18'h0_0003;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [17:0] pinsS;
  reg [17:0] pinsPrev_q;
  wire [17:0] pinsRise;
  wire scl;
  wire sda;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire [2:0] ntcNow;
  wire intBusy;
  wire shortBusy;
  reg shortBusyPrev_q;
  reg [7:0] cfg_q [0:7];
  reg [3:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg firstRd_q;
  reg sdaOe_q;
  reg sdaOut_q;
  reg sclOe_q;
  reg sclOut_q;
  reg wrStb;
  reg hostWrite;
  reg faultRead;
  reg [7:0] rdByte;
  reg loadRead;
  reg [1:0] fltChg_q;
  reg fltBat_q;
  reg [1:0] chgFaultNow;
  wire latchHas;
  wire newFault;
  wire anyIrq;
  reg defaultMode_q;
  reg hostIntN_q;
  reg converterOn_q;
  reg chargeEnable_q;
  reg terminationEnable_q;
  reg timerHalfRate_q;
  reg safetyExpired_q;
  reg batterySwitchOn_q;
  reg chargeLow100mA_q;
  reg [31:0] secCnt_q;
  reg halfPhase_q;
  reg [31:0] safeSec_q;
  reg [31:0] wdtSec_q;
  reg [31:0] wdtLimit;
  wire secTick;
  wire safeExpireEv;
  wire wdtExpire;
  wire [1:0] wdtCode;
  integer i;

  // ****************************************************************
  // Input synchronisation and edges
  // ****************************************************************
  // Every pin input passes three stages before use.
  chgp_sync #(.W(18), .INIT(SYNC_INIT)) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({srcTypeIn, chargePhaseIn, thermistorFaultIn, batteryShortIn,
      batteryOvIn, thermalSdIn, thermalRegIn, chargeDoneIn, inputOvIn,
      inputRemovedIn, goodInputIn, srcIdentIn, sdaIn, sclIn}),
    .syncOut(pinsS)
  );

  // Previous sample for edge detection.
  always @(posedge clk_sys) begin
    if (rst) begin
      pinsPrev_q <= SYNC_INIT;
    end else begin
      pinsPrev_q <= pinsS;
    end
  end

  // Bus edges and conditions; start and stop need the clock high.
  assign pinsRise = pinsS & ~pinsPrev_q;
  assign scl = pinsS[0];
  assign sda = pinsS[1];
  assign sclRise = scl & ~pinsPrev_q[0];
  assign sclFall = ~scl & pinsPrev_q[0];
  assign startCond = scl & pinsPrev_q[0] & pinsPrev_q[1] & ~sda;
  assign stopCond = scl & pinsPrev_q[0] & ~pinsPrev_q[1] & sda;
  assign ntcNow = pinsS[13:11];

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  // Pick the byte to send; a fault read past the first byte sends zero.
  always @* begin
    rdByte = 8'h00;
    faultRead = 1'b0;
    loadRead = sclFall & ((state_q == ST_AACK & rw_q) | state_q == ST_RACK);
    if (ptr_q <= `CHGP_ADDR_LAST_RW) begin
      rdByte = cfg_q[ptr_q[2:0]];
    end else if (ptr_q == `CHGP_ADDR_STATUS) begin
      rdByte = {pinsS[17:16], pinsS[15:14], pinsS[3], 1'b0, pinsS[7], 1'b0};
    end else if (ptr_q == `CHGP_ADDR_FAULT) begin
      if (firstRd_q) begin
        rdByte = {defaultMode_q, 1'b0, fltChg_q, fltBat_q, ntcNow};
        faultRead = loadRead;
      end
    end else if (ptr_q == `CHGP_ADDR_IDENT) begin
      rdByte = `CHGP_IDENT_VALUE;
    end
  end

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  // Slave sequencer: shift on rising clock, drive on falling clock.
  always @(posedge clk_sys) begin
    wrStb <= 1'b0;
    hostWrite <= 1'b0;
    if (rst) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      firstRd_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else if (startCond) begin
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= ST_IDLE;
      sdaOe_q <= 1'b0;
    end else if (loadRead) begin
      shift_q <= rdByte;
      sdaOe_q <= ~rdByte[7];
      bitCnt_q <= 4'h1;
      firstRd_q <= 1'b0;
      state_q <= ST_RDATA;
      if (ptr_q < `CHGP_ADDR_FAULT) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end else begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == `CHGP_SLAVE_ADDR) begin
                sdaOe_q <= 1'b1;
                rw_q <= shift_q[0];
                hostWrite <= ~shift_q[0];
                firstRd_q <= 1'b1;
                state_q <= ST_AACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (state_q == ST_PTR) begin
              if (shift_q <= `CHGP_ADDR_IDENT) begin
                ptr_q <= shift_q;
                sdaOe_q <= 1'b1;
                state_q <= ST_PACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              wrStb <= 1'b1;
              sdaOe_q <= 1'b1;
              state_q <= ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            state_q <= ST_PTR;
          end
        end
        ST_PACK, ST_WACK: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            state_q <= ST_WDATA;
            if (state_q == ST_WACK && ptr_q < `CHGP_ADDR_FAULT) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              sdaOe_q <= 1'b0;
              bitCnt_q <= 4'h0;
              state_q <= ST_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sdaOe_q <= ~shift_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise && sda) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // Clock is never stretched: every answer is ready at once.
  always @(posedge clk_sys) begin
    if (rst) begin
      sdaOut_q <= 1'b0;
      sclOut_q <= 1'b0;
      sclOe_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
      sclOut_q <= 1'b0;
      sclOe_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers and watchdog
  // ****************************************************************
  assign wdtCode = cfg_q[5][`CHGP_TT_WDT_HI:`CHGP_TT_WDT_LO];
  assign wdtExpire = ~defaultMode_q & wdtCode != 2'h0 & wdtSec_q >= wdtLimit;

  // Watchdog interval doubles with each code step.
  always @* begin
    case (wdtCode)
      2'h1: wdtLimit = WDT_BASE_SEC;
      2'h2: wdtLimit = {WDT_BASE_SEC[30:0], 1'b0};
      2'h3: wdtLimit = {WDT_BASE_SEC[29:0], 2'h0};
      default: wdtLimit = 32'h0000_0000;
    endcase
  end

  // Registers load from writes; expiry or reset restores defaults.
  always @(posedge clk_sys) begin
    if (rst || wdtExpire || (wrStb && ptr_q == `CHGP_ADDR_POWER_ON &&
        shift_q[`CHGP_PWR_REG_RESET])) begin
      for (i = 0; i < 8; i = i + 1) begin
        cfg_q[i] <= (i == 0) ? `CHGP_RST_INPUT_SRC :
          (i == 1) ? `CHGP_RST_POWER_ON :
          (i == 5) ? `CHGP_RST_TERM_TIMER : `CHGP_RST_OTHER;
      end
    end else if (wrStb && ptr_q <= `CHGP_ADDR_LAST_RW) begin
      cfg_q[ptr_q[2:0]] <= (ptr_q == `CHGP_ADDR_POWER_ON) ?
        {2'h0, shift_q[5:0]} : shift_q;
    end
  end

  // Mode flag and watchdog seconds counter.
  always @(posedge clk_sys) begin
    if (rst) begin
      defaultMode_q <= 1'b1;
      wdtSec_q <= 32'h0000_0000;
    end else begin
      if (wdtExpire) begin
        defaultMode_q <= 1'b1;
      end else if (hostWrite) begin
        defaultMode_q <= 1'b0;
      end
      if (defaultMode_q || wdtCode == 2'h0 || (wrStb &&
          ((ptr_q == `CHGP_ADDR_POWER_ON && shift_q[`CHGP_PWR_WDT_KICK]) ||
          ptr_q == `CHGP_ADDR_TERM_TIMER))) begin
        wdtSec_q <= 32'h0000_0000;
      end else if (secTick) begin
        wdtSec_q <= wdtSec_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Safety timer
  // ****************************************************************
  assign secTick = secCnt_q == SEC_CYCLES - 32'h0000_0001;
  assign safeExpireEv = ~safetyExpired_q & safeSec_q >= SAFETY_SEC;

  // Second prescaler and the charge safety timer.
  always @(posedge clk_sys) begin
    if (rst) begin
      secCnt_q <= 32'h0000_0000;
      halfPhase_q <= 1'b0;
      safeSec_q <= 32'h0000_0000;
      safetyExpired_q <= 1'b0;
    end else begin
      secCnt_q <= secTick ? 32'h0000_0000 : secCnt_q + 32'h0000_0001;
      if (secTick) begin
        halfPhase_q <= ~halfPhase_q;
      end
      if (!cfg_q[1][`CHGP_PWR_CHG_EN] || !cfg_q[5][`CHGP_TT_SAFE_EN]) begin
        safeSec_q <= 32'h0000_0000;
        safetyExpired_q <= 1'b0;
      end else if (safeExpireEv) begin
        safetyExpired_q <= 1'b1;
      end else if (secTick && !safetyExpired_q &&
          (!pinsS[7] || halfPhase_q)) begin
        safeSec_q <= safeSec_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Fault latch and interrupt
  // ****************************************************************
  // Present charge fault code, shutdown taking precedence.
  always @* begin
    if (pinsS[8]) begin
      chgFaultNow = `CHGP_CF_THERM_SD;
    end else if (pinsS[5]) begin
      chgFaultNow = `CHGP_CF_INPUT_OV;
    end else if (safetyExpired_q) begin
      chgFaultNow = `CHGP_CF_TIMER;
    end else begin
      chgFaultNow = `CHGP_CF_NONE;
    end
  end

  assign latchHas = fltChg_q != `CHGP_CF_NONE || fltBat_q;
  assign newFault = pinsRise[8] | pinsRise[5] | pinsRise[9] | safeExpireEv;
  // Status events, input overvoltage and thermistor changes to a nonzero code always interrupt; other faults only when nothing is latched.
  assign anyIrq = pinsRise[2] | pinsRise[3] | pinsRise[4] | pinsRise[5] |
    pinsRise[6] | (newFault & ~latchHas) |
    (ntcNow != pinsPrev_q[13:11] && ntcNow != 3'h0);

  // Latch holds the first charge fault code and a sticky battery bit until read; a read reloads present state.
  always @(posedge clk_sys) begin
    if (rst) begin
      fltChg_q <= `CHGP_CF_NONE;
      fltBat_q <= 1'b0;
    end else if (faultRead) begin
      fltChg_q <= chgFaultNow;
      fltBat_q <= pinsS[9];
    end else begin
      if (fltChg_q == `CHGP_CF_NONE) begin
        fltChg_q <= chgFaultNow;
      end
      if (pinsS[9]) begin
        fltBat_q <= 1'b1;
      end
    end
  end

  // Pulse generator for the host interrupt.
  chgp_oneshot #(.CYCLES(INT_CYCLES)) uIntShot (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(anyIrq),
    .busy(intBusy)
  );

  // Delay before the battery switch closes again after a short.
  chgp_oneshot #(.CYCLES(SHORT_CYCLES)) uShortShot (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(pinsRise[10]),
    .busy(shortBusy)
  );

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Protection reactions and status drives, all registered.
  always @(posedge clk_sys) begin
    if (rst) begin
      hostIntN_q <= 1'b1;
      converterOn_q <= 1'b0;
      chargeEnable_q <= 1'b0;
      terminationEnable_q <= 1'b0;
      timerHalfRate_q <= 1'b0;
      batterySwitchOn_q <= 1'b1;
      chargeLow100mA_q <= 1'b0;
      shortBusyPrev_q <= 1'b0;
    end else begin
      hostIntN_q <= ~intBusy;
      converterOn_q <= ~pinsS[8] & ~pinsS[5];
      chargeEnable_q <= cfg_q[1][`CHGP_PWR_CHG_EN] & ~pinsS[9] &
        ~safetyExpired_q & ~pinsS[8] & ~pinsS[5];
      terminationEnable_q <= cfg_q[5][`CHGP_TT_TERM_EN] & ~pinsS[7];
      timerHalfRate_q <= pinsS[7];
      shortBusyPrev_q <= shortBusy;
      if (pinsRise[10]) begin
        batterySwitchOn_q <= 1'b0;
      end else if (shortBusyPrev_q && !shortBusy) begin
        batterySwitchOn_q <= 1'b1;
        chargeLow100mA_q <= pinsS[10];
      end else if (!pinsS[10]) begin
        chargeLow100mA_q <= 1'b0;
      end
    end
  end

  // Outputs taken straight from flip-flops.
  assign sclOut = sclOut_q;
  assign sclOe = sclOe_q;
  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign hostIntN = hostIntN_q;
  assign defaultMode = defaultMode_q;
  assign converterOn = converterOn_q;
  assign chargeEnable = chargeEnable_q;
  assign terminationEnable = terminationEnable_q;
  assign timerHalfRate = timerHalfRate_q;
  assign safetyExpired = safetyExpired_q;
  assign batterySwitchOn = batterySwitchOn_q;
  assign chargeLow100mA = chargeLow100mA_q;
  assign inputSourceCfg = cfg_q[0];
  assign powerOnCfg = cfg_q[1];
  assign termTimerCfg = cfg_q[5];
endmodule // chgp_top

// >>> dv/chgp_checker.sv
// Assertion checker bound to the charger host port top module.
`timescale 1ns/10ps
module chgp_checker #(parameter [31:0] INT_CYCLES = 32'h0000_0010) (
  input wire clk_sys, rst, sclIn, sdaOe, hostIntN, defaultMode, // Clock, bus.
  input wire thermalSdIn, inputOvIn, batteryOvIn, thermalRegIn, // Faults.
  input wire converterOn, chargeEnable, timerHalfRate, // Charge controls.
  input wire terminationEnable, batteryShortIn, batterySwitchOn, // Battery.
  input wire [7:0] inputSourceCfg, powerOnCfg, termTimerCfg // Config.
);
  reg [31:0] lowCnt_q;
  // Counts the low cycles of the present interrupt pulse.
  always @(posedge clk_sys) begin
    if (rst || hostIntN) lowCnt_q <= 32'h0000_0000;
    else lowCnt_q <= lowCnt_q + 32'h0000_0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_int; $rose(hostIntN) |-> lowCnt_q >= INT_CYCLES; endproperty
  a_int: assert property (p_int) else $error("Short pulse.");
  property p_sd; thermalSdIn [*8] |-> !converterOn; endproperty
  a_sd: assert property (p_sd) else $error("Converter on.");
  property p_ov; inputOvIn [*8] |-> !converterOn; endproperty
  a_ov: assert property (p_ov) else $error("Switching on.");
  property p_bov; batteryOvIn [*8] |-> !chargeEnable; endproperty
  a_bov: assert property (p_bov) else $error("Charge on.");
  property p_treg;
    thermalRegIn [*8] |-> timerHalfRate && !terminationEnable;
  endproperty
  a_treg: assert property (p_treg) else $error("Regulation.");
  property p_sht; $rose(batteryShortIn) |-> ##[1:8] !batterySwitchOn; endproperty
  a_sht: assert property (p_sht) else $error("Switch on.");
  property p_rst;
    $fell(rst) |-> defaultMode && inputSourceCfg == 8'h58 &&
      powerOnCfg == 8'h1b && termTimerCfg == 8'h9c;
  endproperty
  a_rst: assert property (p_rst) else $error("Reset state.");
  property p_sda; sclIn [*8] |-> $stable(sdaOe); endproperty
  a_sda: assert property (p_sda) else $error("Data moved.");
  c_int: cover property ($fell(hostIntN));
  c_host: cover property ($fell(defaultMode));
  c_sht: cover property ($fell(batterySwitchOn));
endmodule // chgp_checker
bind chgp_top chgp_checker #(.INT_CYCLES(INT_CYCLES)) chk (.*);

// >>> dv/chgp_host_model.sv
// Behavioural serial bus master standing in for the host controller.
`timescale 1ns/10ps
module chgp_host_model (
  output reg scl, // Clock drive, 0 pulls low.
  output reg sda, // Data drive, 0 pulls low.
  input wire sdaW // Resolved data line.
);
  reg [6:0] adr = 7'h6b; // Address used by the transfers.
  initial {scl, sda} = 2'b11;
  // Start or repeated start: data falls while the clock is high.
  task st; begin
    sda = 1'b1; #40 scl = 1'b1; #40 sda = 1'b0; #40 scl = 1'b0; #40;
  end endtask
  // Stop: data rises while the clock is high, then the bus is free.
  task sp; begin
    sda = 1'b0; #40 scl = 1'b1; #40 sda = 1'b1; #80;
  end endtask
  // One byte, data changed only while the clock is low, then the ack.
  task xb(input [7:0] d, input nk, output [7:0] r, output ak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda = d[i]; #40 scl = 1'b1; #40 r[i] = sdaW; #40 scl = 1'b0; #40;
      end
      sda = nk; #40 scl = 1'b1; #40 ak = !sdaW; #40 scl = 1'b0; #40;
    end
  endtask
  // Single register write.
  task wr(input [7:0] p, d, output ok);
    reg [7:0] r;
    reg a, b, c;
    begin
      st; xb({adr, 1'b0}, 1'b1, r, a); xb(p, 1'b1, r, b); xb(d, 1'b1, r, c); sp;
      ok = a & b & c;
    end
  endtask
  // Single byte read through a repeated start; the master nacks it.
  task rd(input [7:0] p, output [7:0] d, output ok);
    reg a, b, c, x;
    begin
      st; xb({adr, 1'b0}, 1'b1, d, a); xb(p, 1'b1, d, b);
      st; xb({adr, 1'b1}, 1'b1, d, c); xb(8'hff, 1'b1, d, x); sp;
      ok = a & b & c;
    end
  endtask
endmodule // chgp_host_model

// >>> dv/chgp_top_bench.sv
// Self-checking bench for the charger host port.
`timescale 1ns/10ps
module chgp_top_bench;
  reg clk_sys = 1'b0, rst = 1'b1, inputOvIn = 1'b0, thermalRegIn = 1'b0;
  reg thermalSdIn = 1'b0, batteryOvIn = 1'b0, batteryShortIn = 1'b0;
  reg [3:0] ev = 4'h0;
  reg [2:0] thermistorFaultIn = 3'h0;
  reg [3:0] stsIn = 4'h9;
  reg [7:0] d;
  reg ok;
  reg [23:0] rows [0:4];
  integer fail_count = 0, compares = 0, k;
  wire mSc, mSd, sclOe, sdaOe, hostIntN, defaultMode, converterOn;
  wire chargeEnable, batterySwitchOn, chargeLow100mA;
  wire [7:0] inputSourceCfg, powerOnCfg, termTimerCfg;
  wire sclIn = mSc & ~sclOe;
  wire sdaIn = mSd & ~sdaOe;
  always #2.5 clk_sys = ~clk_sys;
  chgp_host_model mst (.scl(mSc), .sda(mSd), .sdaW(sdaIn));
  chgp_top #(.INT_CYCLES(32'h0000_0010), .SHORT_CYCLES(32'h0000_0020),
    .SEC_CYCLES(32'h0000_0014), .SAFETY_SEC(32'h0000_2000),
    .WDT_BASE_SEC(32'h0000_0003)) dut (.clk_sys(clk_sys), .rst(rst),
    .sclIn(sclIn), .sclOut(), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(),
    .sdaOe(sdaOe), .srcIdentIn(ev[0]), .goodInputIn(ev[1]),
    .inputRemovedIn(ev[2]), .inputOvIn(inputOvIn), .chargeDoneIn(ev[3]),
    .thermalRegIn(thermalRegIn), .thermalSdIn(thermalSdIn),
    .batteryOvIn(batteryOvIn), .batteryShortIn(batteryShortIn),
    .thermistorFaultIn(thermistorFaultIn), .chargePhaseIn(stsIn[1:0]),
    .srcTypeIn(stsIn[3:2]), .hostIntN(hostIntN), .defaultMode(defaultMode),
    .converterOn(converterOn), .chargeEnable(chargeEnable),
    .terminationEnable(), .timerHalfRate(), .safetyExpired(),
    .batterySwitchOn(batterySwitchOn), .chargeLow100mA(chargeLow100mA),
    .inputSourceCfg(inputSourceCfg), .powerOnCfg(powerOnCfg),
    .termTimerCfg(termTimerCfg));
  // Compares one value and counts the outcome.
  task chk(input string nm, input [31:0] e, s); begin
    compares = compares + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  end endtask
  task tick(input integer n); repeat (n) @(posedge clk_sys); endtask
  // Counts interrupt low cycles over a fixed window.
  task pulse(input [31:0] e);
    integer i, n;
    begin
      n = 0;
      for (i = 0; i < 60; i = i + 1) begin
        @(posedge clk_sys);
        if (hostIntN === 1'b0) n = n + 1;
      end
      chk("intLength", e, n);
    end
  endtask
  task close_out; begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    rows = '{24'h05_8c8c, 24'h00_a5a5, 24'h01_5515, 24'h08_ff90, 24'h0a_0025};
    tick(4); rst <= 1'b0; tick(8);
    chk("defaultMode", 1, defaultMode);
    chk("cfg", 24'h581b_9c, {inputSourceCfg, powerOnCfg, termTimerCfg});
    $display("reset test done");
    for (k = 0; k < 5; k = k + 1) begin
      mst.wr(rows[k][23:16], rows[k][15:8], ok); chk("wrAck", 1, ok);
      mst.rd(rows[k][23:16], d, ok); chk("readBack", rows[k][7:0], d);
    end
    chk("hostMode", 0, defaultMode);
    $display("row test done");
    batteryOvIn <= 1'b1; pulse(16);
    thermalSdIn <= 1'b1; thermalRegIn <= 1'b1; pulse(0);
    chk("convOn", 0, converterOn); chk("chgEn", 0, chargeEnable);
    stsIn <= 4'h6; mst.rd(8'h08, d, ok); chk("status", 8'h62, d);
    for (k = 0; k < 4; k = k + 1) begin
      ev[k] <= 1'b1; pulse(16); ev[k] <= 1'b0;
    end
    thermistorFaultIn <= 3'h3; pulse(16);
    {batteryOvIn, thermalSdIn, thermalRegIn} <= 3'h0; thermistorFaultIn <= 3'h0;
    tick(10);
    mst.rd(8'h09, d, ok); chk("fault1", 8'h28, d);
    mst.rd(8'h09, d, ok); chk("fault2", 8'h00, d);
    $display("fault test done");
    mst.rd(8'h0b, d, ok); chk("nackPtr", 0, ok);
    mst.adr = 7'h6a; mst.wr(8'h00, 8'h00, ok); chk("nackAdr", 0, ok);
    mst.adr = 7'h6b; chk("srcCfg", 8'ha5, inputSourceCfg);
    batteryShortIn <= 1'b1; inputOvIn <= 1'b1; tick(10);
    chk("swOff", 0, batterySwitchOn); chk("convOff", 0, converterOn);
    tick(40);
    chk("swOn", 2'h3, {batterySwitchOn, chargeLow100mA});
    batteryShortIn <= 1'b0; inputOvIn <= 1'b0;
    $display("refusal and short test done");
    mst.wr(8'h05, 8'h9c, ok); tick(100);
    chk("wdtMode", 1, defaultMode); chk("wdtCfg", 8'h58, inputSourceCfg);
    $display("watchdog test done");
    close_out;
  end
endmodule // chgp_top_bench
